// ===== verilog/tx_front_pkg.sv
// shared constants and types for the transmit parity check and encode front end
`default_nettype none

package tx_front_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // register map (byte addresses)
  localparam logic [7:0]  CTRL_OFFSET   = 8'h00;
  localparam logic [7:0]  STATUS_OFFSET = 8'h04;
  localparam logic [7:0]  CTRL_RESET    = 8'h00;
  localparam int          STICKY_POS    = 8;

  ////////////////////////////////////////////////////////////////////////////////
  // three-level select codes
  localparam logic [1:0]  LVL_LOW  = 2'h0;
  localparam logic [1:0]  LVL_MID  = 2'h1;
  localparam logic [1:0]  LVL_HIGH = 2'h2;

  ////////////////////////////////////////////////////////////////////////////////
  // characters, bit 0 holds the first bit on the line
  localparam logic [9:0]  C07_POS  = 10'h079;
  localparam logic [9:0]  C07_NEG  = 10'h386;
  localparam logic [7:0]  K28_5    = 8'hbc;
  localparam logic [3:0]  WS_LAST  = 4'hf;
  localparam int          K_COUNT  = 12;
  localparam logic [7:0]  K_CODES [K_COUNT] = '{
    8'h1c, 8'h3c, 8'h5c, 8'h7c, 8'h9c, 8'hbc,
    8'hdc, 8'hfc, 8'hf7, 8'hfb, 8'hfd, 8'hfe
  };

  ////////////////////////////////////////////////////////////////////////////////
  // self-test generator
  localparam logic [8:0]  BIST_SEED = 9'h1ff;
  localparam int          BIST_LEN  = 511;

  ////////////////////////////////////////////////////////////////////////////////
  // types
  typedef struct packed {
    logic       table_sel;
    logic       bist_en;
    logic [1:0] par_sel;
    logic [1:0] mode_up;
    logic [1:0] mode_lo;
  } ctrl_type;

  typedef struct packed {
    logic       odd_par;
    logic       special_sel;
    logic [1:0] ctl;
    logic [7:0] byte_v;
  } tx_char_type;

  typedef enum logic [1:0] {
    WS_IDLE = 2'b01,
    WS_RUN  = 2'b10
  } ws_state_type;

endpackage

`default_nettype wire

// ===== verilog/enc_8b10b_core.sv
// combinational 8b/10b character encoder with running disparity
`default_nettype none

module enc_8b10b_core (
  input  wire logic [7:0] i_byte,
  input  wire logic       i_k,
  input  wire logic       i_rd,
  output logic      [9:0] o_code,
  output logic            o_rd
);

  // minus-disparity forms, abcdei and fghj, first bit on the left
  localparam logic [5:0] T6 [32] = '{
    6'h27, 6'h1d, 6'h2d, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
    6'h39, 6'h25, 6'h15, 6'h34, 6'h0d, 6'h2c, 6'h1c, 6'h17,
    6'h1b, 6'h23, 6'h13, 6'h32, 6'h0b, 6'h2a, 6'h1a, 6'h3a,
    6'h33, 6'h26, 6'h16, 6'h36, 6'h0e, 6'h2e, 6'h1e, 6'h2b
  };
  localparam logic [3:0] T4 [8] = '{
    4'hb, 4'h9, 4'h5, 4'hc, 4'hd, 4'ha, 4'h6, 4'he
  };

  logic [4:0] x;
  logic [2:0] y;
  logic [5:0] s6m;
  logic [5:0] s6;
  logic       un6;
  logic       rd6;
  logic       alt7;
  logic [3:0] s4m;
  logic [3:0] s4;
  logic       un4;
  logic       flip4;
  logic [9:0] seq;

  assign x     = i_byte[4:0];
  assign y     = i_byte[7:5];
  assign s6m   = (i_k && x == 5'h1c) ? 6'h0f : T6[x];
  assign un6   = $countones(s6m) != 3;
  assign s6    = (i_rd && (un6 || (x == 5'h07 && !i_k))) ? ~s6m : s6m;
  assign rd6   = i_rd ^ un6;
  assign alt7  = (y == 3'h7) && (i_k ||
                 (!rd6 && (x == 5'h11 || x == 5'h12 || x == 5'h14)) ||
                 (rd6 && (x == 5'h0b || x == 5'h0d || x == 5'h0e)));
  assign s4m   = alt7 ? 4'h7 : T4[y];
  assign un4   = $countones(s4m) != 2;
  assign flip4 = rd6 ? (un4 || y == 3'h3) : (i_k && !un4 && y != 3'h3);
  assign s4    = flip4 ? ~s4m : s4m;
  assign o_rd  = rd6 ^ un4;
  assign seq   = {s6, s4};

  // bit a lands in bit 0 so the line sees it first
  genvar gi;
  generate
    for (gi = 0; gi < 10; gi++)
    begin : g_rev
      assign o_code[gi] = seq[9-gi];
    end
  endgenerate

endmodule

`default_nettype wire

// ===== verilog/bist_seq_gen.sv
// self-test character source, maximal 9-bit sequence of 511 states
`default_nettype none

module bist_seq_gen
  import tx_front_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_enable,
  output logic      [7:0] o_byte
);

  logic [8:0] lfsr_q;
  logic [8:0] lfsr_d;

  // x^9 + x^5 + 1; restarts from the seed whenever the source is off
  assign lfsr_d = i_enable ? {lfsr_q[7:0], lfsr_q[8] ^ lfsr_q[4]} : BIST_SEED;
  assign o_byte = lfsr_q[7:0];

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      lfsr_q <= BIST_SEED;
    else
      lfsr_q <= lfsr_d;
  end

endmodule

`default_nettype wire

// ===== verilog/tx_parity_check_8b10b_encode.sv
// transmit channel front end: parity check, mode decode, 8b/10b encode
//
// Function
// [RQ1] capture odd parity bit, check in every mode; code skips it in self-test and on atomic sync chars after the first
// [RQ2] mid select, encoder on: byte plus parity
// [RQ3] high encoded, or mid bypass: all bits
// [RQ4] select low: no checking, no error
// [RQ5] parity valid when xor of bits is one
// [RQ6] encoded parity error sends disparity-correct C0.7
// [RQ7] bypass parity error sends positive C0.7
// [RQ8] positive C0.7 pattern is 1001111000
// [RQ9] every parity error raises channel error flag
// [RQ10] buffer error forces C0.7 on output
// [RQ11] 511-character self-test source replaces host characters
// [RQ12] K28.5 single or in 16-character sync
// [RQ13] output chosen by mode, select, control, byte
// [RQ14] one 10-bit character per input character
// [RQ15] special and data codes, disparity tracked
// [RQ16] two separate special code tables
// [RQ17] character leaves least significant bit first
// [RQ18] mode selects static, host never changes them
// [RQ19] modes 3-8 encode, mode 0 bypasses
// [RQ20] test modes 1 and 2 harmless
// [RQ21] mid upper select atomic, high interruptible sync
// [RQ22] mode number is three upper plus lower
`default_nettype none

module tx_parity_check_8b10b_encode
  import tx_front_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic      [31:0] o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  input  wire logic [7:0]  i_tx_char_byte,
  input  wire logic [1:0]  i_tx_char_control,
  input  wire logic        i_char_odd_parity_in,
  input  wire logic        i_special_code_select,
  input  wire logic        i_align_error,
  output logic      [9:0]  o_tx_char,
  output logic             o_tx_channel_error_flag,
  output logic             o_word_sync_active
);

  ////////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [1:0] lvl(input logic [1:0] c);
    lvl = (c == 2'h3) ? LVL_HIGH : c;
  endfunction

  // {valid, code}; table 0 indexes the list, table 1 takes the raw code
  function automatic logic [8:0] k_lookup(input logic [7:0] b, input logic tbl);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < K_COUNT; i++)
    begin
      if (K_CODES[i] == b)
        hit = 1'b1;
    end
    if (tbl)
      k_lookup = {hit, b};
    else if (b[7:4] == 4'h0 && b[3:0] < 4'hc)
      k_lookup = {1'b1, K_CODES[b[3:0]]};
    else
      k_lookup = 9'h000;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // declarations

  ctrl_type     ctrl_q;
  ctrl_type     ctrl_d;
  tx_char_type  in_q;
  ws_state_type ws_q;
  ws_state_type ws_d;
  logic [3:0]   ws_cnt_q;
  logic [3:0]   ws_cnt_d;
  logic         align_q;
  logic         rd_q;
  logic         rd_d;
  logic [9:0]   char_q;
  logic [9:0]   char_d;
  logic         err_q;
  logic         err_d;
  logic         sticky_q;
  logic         sticky_d;
  logic [7:0]   addr_q;
  logic         wr_q;
  logic [31:0]  rdata_q;
  logic [31:0]  rdata_w;
  logic         bus_take;
  logic         wr_ctrl;
  logic         clr_sticky;
  logic [1:0]   mode_up;
  logic [1:0]   mode_lo;
  logic [1:0]   par_sel;
  logic [3:0]   mode_num;
  logic         enc_en;
  logic         atomic;
  logic         ws_run;
  logic         chk_en;
  logic         byte_only;
  logic         par_byte;
  logic         par_all;
  logic         par_err;
  logic [1:0]   ct;
  logic         sc;
  logic         tbl_b;
  logic         tbl_c;
  logic         ws_trig;
  logic         k_fill;
  logic         spec;
  logic         ws_go;
  logic         ws_cont;
  logic         ws_emit;
  logic [8:0]   k_res;
  logic         k_bad;
  logic [7:0]   bist_byte;
  logic [7:0]   enc_byte;
  logic         enc_k;
  logic [9:0]   enc_code;
  logic         enc_rd;
  logic         use_enc;
  logic [9:0]   c07_w;

  ////////////////////////////////////////////////////////////////////////////////
  // register bus slave, zero wait states

  assign bus_take    = i_hsel && i_htrans[1] && i_hready;
  assign wr_ctrl     = wr_q && addr_q == CTRL_OFFSET;
  assign clr_sticky  = wr_q && addr_q == STATUS_OFFSET && i_hwdata[STICKY_POS];
  assign ctrl_d      = wr_ctrl ? ctrl_type'(i_hwdata[7:0]) : ctrl_q;
  // a new error wins over a clear in the same cycle
  assign sticky_d    = par_err || (sticky_q && !clr_sticky);    // see [RQ9]
  assign o_hrdata    = rdata_q;
  assign o_hreadyout = 1'b1;
  assign o_hresp     = 1'b0;

  always_comb
  begin
    if (i_haddr[7:0] == CTRL_OFFSET)
      rdata_w = {24'h000000, ctrl_q};
    else if (i_haddr[7:0] == STATUS_OFFSET)
      rdata_w = {23'h000000, sticky_q, mode_num, 1'b0, rd_q, ws_run, err_q};
    else
      rdata_w = 32'h00000000;
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      addr_q   <= 8'h00;
      wr_q     <= 1'b0;
      rdata_q  <= 32'h00000000;
      ctrl_q   <= ctrl_type'(CTRL_RESET);
      sticky_q <= 1'b0;
    end
    else
    begin
      addr_q   <= bus_take ? i_haddr[7:0] : addr_q;
      wr_q     <= bus_take && i_hwrite;
      rdata_q  <= (bus_take && !i_hwrite) ? rdata_w : rdata_q;
      ctrl_q   <= ctrl_d;
      sticky_q <= sticky_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // mode decode, the selects are held static by software

  assign mode_up  = lvl(ctrl_q.mode_up);                        // see [RQ18]
  assign mode_lo  = lvl(ctrl_q.mode_lo);
  assign par_sel  = lvl(ctrl_q.par_sel);
  assign mode_num = {1'b0, mode_up, 1'b0} + {2'h0, mode_up} + {2'h0, mode_lo}; // see [RQ22]
  // modes 1 and 2 run as plain bypass
  assign enc_en   = mode_up != LVL_LOW;                         // see [RQ19] see [RQ20]
  assign atomic   = mode_up == LVL_MID;                         // see [RQ21]
  assign ws_run   = ws_q == WS_RUN;

  ////////////////////////////////////////////////////////////////////////////////
  // input register and parity check

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      in_q    <= '0;
      align_q <= 1'b0;
    end
    else
    begin
      in_q    <= {i_char_odd_parity_in, i_special_code_select,
                  i_tx_char_control, i_tx_char_byte};           // see [RQ1]
      align_q <= i_align_error;
    end
  end

  assign par_byte  = ^{in_q.odd_par, in_q.byte_v};
  assign par_all   = ^{in_q.odd_par, in_q.ctl, in_q.byte_v};
  assign byte_only = par_sel == LVL_MID && enc_en;              // see [RQ2]
  // atomic sync characters after the first are not checked
  assign chk_en    = par_sel != LVL_LOW && !ctrl_q.bist_en &&
                     !(atomic && ws_run && enc_en);             // see [RQ4]
  assign par_err   = chk_en && !(byte_only ? par_byte : par_all); // see [RQ3] see [RQ5]

  ////////////////////////////////////////////////////////////////////////////////
  // control decode per encoding table

  assign ct      = in_q.ctl;
  assign sc      = in_q.special_sel;
  assign tbl_b   = mode_lo == LVL_MID;
  assign tbl_c   = mode_lo == LVL_HIGH;
  assign ws_trig = tbl_b ? (sc && ct[0]) : (ct == 2'h3);        // see [RQ13]
  assign k_fill  = tbl_c ? (ct == 2'h1) : (!sc && ct == 2'h1);
  assign spec    = !ws_emit && (tbl_c ? (ct == 2'h2) :
                   tbl_b ? (!sc && ct == 2'h3) : (sc && ct == 2'h1));

  ////////////////////////////////////////////////////////////////////////////////
  // word sync sequence, sixteen commas

  assign ws_go    = enc_en && !ctrl_q.bist_en && !ws_run && ws_trig && !par_err;
  assign ws_cont  = atomic || (ct == 2'h0 && !par_err);         // see [RQ21]
  assign ws_emit  = ws_go || (ws_run && ws_cont);               // see [RQ12]
  assign ws_d     = ws_go ? WS_RUN :
                    (ws_run && ws_cont && ws_cnt_q != WS_LAST) ? WS_RUN : WS_IDLE;
  assign ws_cnt_d = ws_go ? 4'h1 : (ws_d == WS_RUN) ? ws_cnt_q + 4'h1 : 4'h0;

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      ws_q     <= WS_IDLE;
      ws_cnt_q <= 4'h0;
    end
    else
    begin
      ws_q     <= ws_d;
      ws_cnt_q <= ws_cnt_d;
    end
  end

  assign o_word_sync_active = ws_run;

  ////////////////////////////////////////////////////////////////////////////////
  // character sources and encoder

  bist_seq_gen u_bist (
    .i_clk    (i_clk),
    .i_rst_n  (i_rst_n),
    .i_enable (ctrl_q.bist_en),                                 // see [RQ11]
    .o_byte   (bist_byte)
  );

  assign k_res    = k_lookup(in_q.byte_v, ctrl_q.table_sel);    // see [RQ16]
  assign k_bad    = spec && !k_res[8];
  assign enc_byte = ctrl_q.bist_en ? bist_byte :
                    (ws_emit || k_fill) ? K28_5 :
                    spec ? k_res[7:0] : in_q.byte_v;
  assign enc_k    = !ctrl_q.bist_en && (ws_emit || k_fill || spec); // see [RQ15]

  enc_8b10b_core u_enc (
    .i_byte (enc_byte),
    .i_k    (enc_k),
    .i_rd   (rd_q),
    .o_code (enc_code),
    .o_rd   (enc_rd)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // output selection, one character out per character in

  assign c07_w   = (!enc_en || rd_q) ? C07_POS : C07_NEG;       // see [RQ6]
  assign use_enc = !align_q && (ctrl_q.bist_en || (enc_en && !par_err && !k_bad));
  assign char_d  = align_q ? c07_w :                            // see [RQ10]
                   ctrl_q.bist_en ? enc_code :
                   !enc_en ? (par_err ? C07_POS : {ct, in_q.byte_v}) : // see [RQ7] see [RQ8]
                   (par_err || k_bad) ? c07_w : enc_code;       // see [RQ14]
  assign rd_d    = use_enc ? enc_rd : rd_q;
  assign err_d   = par_err || align_q;                          // see [RQ9]

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      char_q <= C07_POS;
      err_q  <= 1'b0;
      rd_q   <= 1'b0;
    end
    else
    begin
      char_q <= char_d;
      err_q  <= err_d;
      rd_q   <= rd_d;
    end
  end

  // bit 0 is the first bit on the line
  assign o_tx_char               = char_q;                      // see [RQ17]
  assign o_tx_channel_error_flag = err_q;

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  sequence s_ws_atomic_go;
    ws_go && atomic;
  endsequence

  sequence s_ws_hold;
    ws_run[*8] ##1 ws_run[*7] ##1 !ws_run;
  endsequence

  a_par_off_quiet: assert property ( // see [RQ4]
    (par_sel == LVL_LOW && !align_q) |=> !o_tx_channel_error_flag)
    else $error("parity error flagged with checking off");

  a_bypass_viol: assert property ( // see [RQ7] see [RQ8]
    (!enc_en && par_err && !align_q) |=> o_tx_char == 10'h079)
    else $error("bypass parity error did not send positive C0.7");

  a_enc_viol: assert property ( // see [RQ6]
    (enc_en && par_err && !align_q) |=> o_tx_char == (rd_q ? C07_POS : C07_NEG))
    else $error("encoded parity error did not send C0.7");

  a_err_flag: assert property ( // see [RQ9]
    (par_err || align_q) |=> o_tx_channel_error_flag)
    else $error("error not reported on flag");

  a_align_sub: assert property ( // see [RQ10]
    align_q |=> (o_tx_char == C07_POS || o_tx_char == C07_NEG))
    else $error("buffer error did not force C0.7");

  a_bypass_pass: assert property ( // see [RQ19]
    (!enc_en && !par_err && !align_q && !ctrl_q.bist_en)
      |=> o_tx_char == $past({in_q.ctl, in_q.byte_v}))
    else $error("bypass character altered");

  a_ws_atomic: assert property ( // see [RQ21]
    s_ws_atomic_go |=> s_ws_hold)
    else $error("atomic sync sequence not sixteen characters");

  a_ws_comma: assert property ( // see [RQ12]
    (ws_emit && !align_q && !ctrl_q.bist_en)
      |=> (o_tx_char == 10'h17c || o_tx_char == 10'h283))
    else $error("sync sequence character is not a comma");

  a_parity_mid: assert property ( // see [RQ2]
    (byte_only && par_byte && !ws_run) |-> !par_err)
    else $error("control bits included in byte-only check");

  a_ws_break: assert property ( // see [RQ21]
    (ws_run && !atomic && ct != 2'h0) |=> !ws_run)
    else $error("interruptible sync did not terminate");

  a_sticky_set: assert property ( // see [RQ9]
    par_err |=> sticky_q)
    else $error("sticky parity bit lost");

endmodule

`default_nettype wire

// ===== bench/host_char_model.sv
// host side model: presents one character per clock with its odd parity bit
`default_nettype none

module host_char_model
  import tx_front_pkg::*;
(
  input  wire logic        i_req_wide,
  input  wire logic        i_req_bad,
  input  wire tx_char_type i_req,
  output tx_char_type      o_char
);
  timeunit 1ns;
  timeprecision 1ps;

  logic sel_xor;

  // wide covers control bits as well as the byte; bad flips the parity on purpose
  assign sel_xor = (^i_req.byte_v) ^ (i_req_wide & (^i_req.ctl));

  always_comb
  begin
    o_char         = i_req;
    o_char.odd_par = ~sel_xor ^ i_req_bad;
  end
endmodule

`default_nettype wire

// ===== bench/tx_parity_check_8b10b_encode_bench.sv
// self-checking bench for the transmit parity check and encode front end
`default_nettype none

module tx_parity_check_8b10b_encode_bench
  import tx_front_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        i_clk;
  logic        i_rst_n;
  logic        hsel;
  logic        hwrite;
  logic        align_err;
  logic        wide;
  logic        bad;
  logic [1:0]  htrans;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] rd;
  tx_char_type req;
  tx_char_type chr;
  wire  logic [31:0] hrdata;
  wire  logic        hready;
  wire  logic        hresp;
  wire  logic [9:0]  tx_char;
  wire  logic        flag;
  wire  logic        ws;
  int          err_total;
  int          tests_run;

  host_char_model host_u (
    .i_req_wide (wide),
    .i_req_bad  (bad),
    .i_req      (req),
    .o_char     (chr)
  );

  tx_parity_check_8b10b_encode dut_u (
    .i_clk                   (i_clk),
    .i_rst_n                 (i_rst_n),
    .i_hsel                  (hsel),
    .i_haddr                 (haddr),
    .i_htrans                (htrans),
    .i_hwrite                (hwrite),
    .i_hsize                 (3'h2),
    .i_hwdata                (hwdata),
    .i_hready                (hready),
    .o_hrdata                (hrdata),
    .o_hreadyout             (hready),
    .o_hresp                 (hresp),
    .i_tx_char_byte          (chr.byte_v),
    .i_tx_char_control       (chr.ctl),
    .i_char_odd_parity_in    (chr.odd_par),
    .i_special_code_select   (chr.special_sel),
    .i_align_error           (align_err),
    .o_tx_char               (tx_char),
    .o_tx_channel_error_flag (flag),
    .o_word_sync_active      (ws)
  );

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  task automatic close_out;
    if (err_total == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one when the character is either of two forms, such as both disparities
  function automatic logic [31:0] either_of(input logic [9:0] c, input logic [9:0] a,
                                            input logic [9:0] b);
    either_of = {31'h0, (c == a) || (c == b)};
  endfunction

  // bounded wait for hready sampled high at a rising edge
  task automatic wait_rdy;
    int n;
    n = 0;
    @(posedge i_clk);
    while (hready !== 1'b1)
    begin
      n++;
      if (n > 50)
      begin
        err_total++;
        close_out();
      end
      @(posedge i_clk);
    end
  endtask

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge i_clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {24'h0, a};
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask

  // one character, judged once its two-edge latency has passed
  task automatic send(input logic [9:0] raw, input logic w, input logic b);
    @(posedge i_clk);
    req.ctl    <= raw[9:8];
    req.byte_v <= raw[7:0];
    wide       <= w;
    bad        <= b;
    repeat (2) @(posedge i_clk);
    #1;
  endtask

  task automatic do_reset;
    @(posedge i_clk);
    i_rst_n <= 1'b0;
    repeat (16) @(posedge i_clk);
    check("reset_char", {22'h0, tx_char}, {22'h0, C07_POS});
    i_rst_n <= 1'b1;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    ahb(1'b0, CTRL_OFFSET, 32'h0);
    check("ctrl_reset", rd, {24'h0, CTRL_RESET});
    check("resp_okay", {31'h0, hresp}, 32'h0);
    ahb(1'b1, 8'h08, 32'hffff_ffff);
    ahb(1'b0, 8'h08, 32'h0);
    check("unmapped", rd, 32'h0);
    for (int u = 0; u < 3; u++)
      for (int l = 0; l < 3; l++)
      begin
        ahb(1'b1, CTRL_OFFSET, 32'(u * 4 + l));
        ahb(1'b0, STATUS_OFFSET, 32'h0);
        check("mode_num", {28'h0, rd[7:4]}, 32'(3 * u + l));
      end
  endtask

  task automatic t_bypass;
    ahb(1'b1, CTRL_OFFSET, 32'h00);
    send(10'h2a5, 1'b1, 1'b1);
    check("off_char", {22'h0, tx_char}, 32'h2a5);
    check("off_flag", {31'h0, flag}, 32'h0);
    ahb(1'b1, CTRL_OFFSET, 32'h02);
    send(10'h155, 1'b0, 1'b0);
    check("test_mode", {22'h0, tx_char}, 32'h155);
    ahb(1'b1, CTRL_OFFSET, 32'h10);
    send(10'h200, 1'b1, 1'b0);
    check("byp_good", {22'h0, tx_char}, 32'h200);
    check("byp_gflag", {31'h0, flag}, 32'h0);
    send(10'h200, 1'b0, 1'b0);
    check("byp_bad", {22'h0, tx_char}, {22'h0, C07_POS});
    check("byp_pat", {22'h0, tx_char}, 32'h079);
    check("byp_flag", {31'h0, flag}, 32'h1);
    send(10'h200, 1'b1, 1'b0);
    ahb(1'b0, STATUS_OFFSET, 32'h0);
    check("sticky_set", {31'h0, rd[STICKY_POS]}, 32'h1);
    ahb(1'b1, STATUS_OFFSET, 32'h100);
    ahb(1'b0, STATUS_OFFSET, 32'h0);
    check("sticky_clr", {31'h0, rd[STICKY_POS]}, 32'h0);
  endtask

  task automatic t_enc;
    do_reset();
    send(10'h200, 1'b0, 1'b1);
    ahb(1'b1, CTRL_OFFSET, 32'h14);
    send(10'h000, 1'b0, 1'b1);
    check("enc_bad", {22'h0, tx_char}, {22'h0, C07_NEG});
    check("enc_flag", {31'h0, flag}, 32'h1);
    send(10'h200, 1'b0, 1'b0);
    check("mid_byte", {31'h0, flag}, 32'h0);
    ahb(1'b1, CTRL_OFFSET, 32'h24);
    send(10'h200, 1'b0, 1'b0);
    check("high_all", {31'h0, flag}, 32'h1);
  endtask

  // special codes through both tables, then a code that only the first table knows
  task automatic t_special;
    ahb(1'b1, CTRL_OFFSET, 32'h06);
    send(10'h205, 1'b0, 1'b0);
    check("spec_tbl0", either_of(tx_char, 10'h17c, 10'h283), 32'h1);
    ahb(1'b1, CTRL_OFFSET, 32'h86);
    send(10'h2bc, 1'b0, 1'b0);
    check("spec_tbl1", either_of(tx_char, 10'h17c, 10'h283), 32'h1);
    send(10'h205, 1'b0, 1'b0);
    check("spec_bad", either_of(tx_char, C07_POS, C07_NEG), 32'h1);
  endtask

  task automatic t_align_bist;
    logic [9:0] first;
    logic       moved;
    ahb(1'b1, CTRL_OFFSET, 32'h00);
    @(posedge i_clk);
    align_err <= 1'b1;
    repeat (3) @(posedge i_clk);
    #1;
    check("align_char", {22'h0, tx_char}, {22'h0, C07_POS});
    check("align_flag", {31'h0, flag}, 32'h1);
    @(posedge i_clk);
    align_err <= 1'b0;
    ahb(1'b1, CTRL_OFFSET, 32'h50);
    send(10'h200, 1'b1, 1'b1);
    repeat (3) @(posedge i_clk);
    #1;
    check("bist_noflag", {31'h0, flag}, 32'h0);
    // 511 source states, and a disparity that can only flip per pass: repeats after 1022
    first = tx_char;
    moved = 1'b0;
    repeat (1022)
    begin
      @(posedge i_clk);
      #1;
      moved = moved | (tx_char !== first);
    end
    check("bist_period", {22'h0, tx_char}, {22'h0, first});
    check("bist_moves", {31'h0, moved}, 32'h1);
  endtask

  // trigger, three data characters, then a control code that stops only an interruptible run;
  // the flag stays up for the characters after the trigger, fifteen in a full run
  task automatic t_sync(input logic [31:0] ctrl, input logic [31:0] exp_run);
    int cnt;
    cnt = 0;
    ahb(1'b1, CTRL_OFFSET, ctrl);
    send(10'h000, 1'b0, 1'b0);
    @(posedge i_clk);
    req.ctl <= 2'b11;
    for (int i = 1; i < 45; i++)
    begin
      @(posedge i_clk);
      req.ctl <= (i < 4) ? 2'b00 : 2'b01;
      if (ws === 1'b1)
      begin
        cnt++;
        check("sync_comma", either_of(tx_char, 10'h17c, 10'h283), 32'h1);
      end
    end
    check("sync_run", 32'(cnt), exp_run);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    err_total = 0;
    tests_run = 0;
    i_rst_n   = 1'b0;
    hsel      = 1'b0;
    hwrite    = 1'b0;
    htrans    = 2'h0;
    haddr     = 32'h0;
    hwdata    = 32'h0;
    align_err = 1'b0;
    wide      = 1'b0;
    bad       = 1'b0;
    req       = '0;
    do_reset();
    t_regs();
    t_bypass();
    t_enc();
    t_align_bist();
    t_special();
    t_sync(32'h06, 32'd15);
    t_sync(32'h0a, 32'd4);
    close_out();
  end
endmodule

`default_nettype wire
